/* bench/scw_sva.sv */
// scw_sva: link framing and device field checks beside the serial link
// assumes: instantiated in the testbench top next to the link interface
`timescale 1ns/1ps
module scw_sva
	import scw_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic latch_en,
	input wire logic charge_cancel_en,
	input wire logic slip_assist_enable,
	input wire scw_pkg::scw_clkdiv_e clkdiv_mode,
	input wire logic [11:0] clkdiv_value,
	input wire logic [1:0] lock_pin_mode,
	input wire logic [31:0] reserved_fixed_word,
	input wire logic [2:0] slip_cells,
	input wire logic timeout_pulse
);
	// ==========================================================
	// helper: cycles since the load strobe was last high
	logic [3:0] since_le;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) since_le <= 4'hf;
		else if (latch_en) since_le <= 4'h0;
		else if (since_le != 4'hf) since_le <= since_le + 4'h1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// link framing and field updates
	a_latch_len: assert property (
		$rose(latch_en) |-> latch_en [*3] ##1 !latch_en)
		else $error("load strobe not three cycles long");
	a_latch_sclk: assert property (latch_en |-> sclk)
		else $error("load strobe without serial clock high");
	a_sdata_hold: assert property (
		sclk && $past(sclk) |-> $stable(sdata))
		else $error("serial data moved while clock high");
	a_cfg_after_load: assert property (
		$changed({charge_cancel_en, slip_assist_enable, clkdiv_mode,
		clkdiv_value}) |-> since_le < 4'ha)
		else $error("config field changed without a load");
	a_lock_after_load: assert property (
		$changed(lock_pin_mode) |-> since_le < 4'ha)
		else $error("lock pin field changed without a load");
	a_fixed_word: assert property (
		reserved_fixed_word == 32'h0000_0000 ||
		reserved_fixed_word == R4_FIXED)
		else $error("reserved word holds an odd value");
	a_timeout_off: assert property (
		clkdiv_mode == SCW_CLKDIV_OFF &&
		$past(clkdiv_mode) == SCW_CLKDIV_OFF |-> !timeout_pulse)
		else $error("timeout while divider off");
	a_cells_off: assert property (
		!slip_assist_enable && !$past(slip_assist_enable)
		|-> slip_cells == 3'h0)
		else $error("cells active while assist off");
	a_cells_step: assert property (
		slip_cells == $past(slip_cells) ||
		slip_cells == $past(slip_cells) + 3'h1 ||
		slip_cells == $past(slip_cells) - 3'h1 || !slip_assist_enable)
		else $error("cell count jumped");
	c_full: cover property (slip_cells == SLIP_MAX_CELLS);
	c_tout: cover property (timeout_pulse);
	c_load: cover property ($rose(latch_en));
endmodule

/* bench/synth_control_word_decode_test.sv */
// synth_control_word_decode_test: host and device joined over the link
// assumes: package, interface and both ends compiled first
`timescale 1ns/1ps
module synth_control_word_decode_test;
	import scw_pkg::*;
	logic clock, rst_b, wr, rd, slip_imminent, slip_dir_up;
	logic ref_tick = 1'b0; // driven only by its toggle process
	logic lvl_q = 1'b0; // comparator level one cycle back
	logic past_target, charge_cancel_en, slip_assist_enable, pfd_tick;
	logic pfd_level, timeout_pulse, slip_source;
	logic [2:0] addr, slip_cells;
	logic [31:0] wdata, rdata, reserved_fixed_word;
	logic [11:0] clkdiv_value, denominator_setting;
	logic [1:0] lock_pin_mode;
	scw_clkdiv_e clkdiv_mode;
	int n_fail = 0, n_compared = 0, ref_cnt = 0, ref_gap = 0;
	int pfd_cnt = 0, pfd_gap = 0, tout_n = 0;
	int lvl_cnt = 0, hi_len = 0, lo_len = 0;
	scw_if link ();
	scw_host scw_host_i (.clock(clock), .rst_b(rst_b), .link(link),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	scw_device scw_device_i (.clock(clock), .rst_b(rst_b), .link(link),
		.ref_tick(ref_tick), .slip_imminent(slip_imminent),
		.slip_dir_up(slip_dir_up), .past_target(past_target),
		.charge_cancel_en(charge_cancel_en),
		.slip_assist_enable(slip_assist_enable), .clkdiv_mode(clkdiv_mode),
		.clkdiv_value(clkdiv_value), .lock_pin_mode(lock_pin_mode),
		.reserved_fixed_word(reserved_fixed_word),
		.denominator_setting(denominator_setting), .pfd_tick(pfd_tick),
		.pfd_level(pfd_level), .timeout_pulse(timeout_pulse),
		.slip_cells(slip_cells), .slip_source(slip_source));
	scw_sva scw_sva_i (.clock(clock), .rst_b(rst_b), .sclk(link.sclk),
		.sdata(link.sdata), .latch_en(link.latch_en),
		.charge_cancel_en(charge_cancel_en),
		.slip_assist_enable(slip_assist_enable), .clkdiv_mode(clkdiv_mode),
		.clkdiv_value(clkdiv_value), .lock_pin_mode(lock_pin_mode),
		.reserved_fixed_word(reserved_fixed_word), .slip_cells(slip_cells),
		.timeout_pulse(timeout_pulse));
	// ==========================================================
	// clock, reference ticks every other cycle, gap counters
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) ref_tick <= !ref_tick;
	always @(posedge clock) begin
		if (pfd_tick === 1'b1) begin
			ref_gap <= ref_cnt + ref_tick;
			ref_cnt <= 0;
		end else ref_cnt <= ref_cnt + ref_tick;
		if (timeout_pulse === 1'b1) begin
			pfd_gap <= pfd_cnt + (pfd_tick === 1'b1);
			pfd_cnt <= 0;
			tout_n <= tout_n + 1;
		end else pfd_cnt <= pfd_cnt + (pfd_tick === 1'b1);
	end
	// run lengths of the comparator level, high and low
	always @(posedge clock) begin
		lvl_q <= pfd_level;
		if (pfd_level !== lvl_q) begin
			if (lvl_q === 1'b1) hi_len <= lvl_cnt;
			else lo_len <= lvl_cnt;
			lvl_cnt <= 1;
		end else lvl_cnt <= lvl_cnt + 1;
	end
	// ==========================================================
	// word builders and bus tasks
	function automatic logic [31:0] f3(input logic c, input logic s,
		input logic [1:0] m, input logic [11:0] v);
		return {10'h0, c, 2'b00, s, 1'b0, m, v, 3'h3};
	endfunction
	function automatic logic [31:0] f2(input logic d, input logic t,
		input logic [9:0] r);
		return {6'h00, d, t, r, 14'h0002};
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task put(input logic [2:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task get(input logic [2:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// poll status until nothing pending and idle, then let the load land
	task settle;
		logic [31:0] s;
		s = 32'h0;
		for (int i = 0; i < 3000 && s[7:0] !== 8'h80; i++) get(3'h7, s);
		chk("status", 32'h80, {24'h0, s[7:0]});
		repeat (10) @(posedge clock);
	endtask
	task pulse(input logic up);
		slip_dir_up <= up;
		slip_imminent <= 1'b1;
		@(posedge clock);
		slip_imminent <= 1'b0;
		repeat (3) @(posedge clock);
	endtask
	// ==========================================================
	// scenarios
	task t_init;
		logic [31:0] s;
		put(3'h0, 32'h0);
		put(3'h1, {17'h0, 12'hfff, 3'h1});
		put(3'h2, f2(1'b0, 1'b1, 10'd3));
		put(3'h3, f3(1'b1, 1'b1, SCW_CLKDIV_FAST, 12'h003));
		put(3'h4, 32'hffff_fff4);
		put(3'h5, {8'h00, 2'b10, 19'h0, 3'h5});
		settle;
		chk("cancel", 1, charge_cancel_en);
		chk("assist", 1, slip_assist_enable);
		chk("mode", SCW_CLKDIV_FAST, clkdiv_mode);
		chk("divval", 12'h003, clkdiv_value);
		chk("lockpin", 2'b10, lock_pin_mode);
		chk("fixed", R4_FIXED, reserved_fixed_word);
		chk("denom", 12'hfff, denominator_setting);
		get(3'h4, s);
		chk("shadow4", R4_FIXED, s);
		repeat (400) @(posedge clock);
		chk("refgap", 12, ref_gap);
		chk("duty_hi", 12, hi_len);
		chk("duty_lo", 12, lo_len);
		chk("pfdgap", 3, pfd_gap);
	endtask
	task t_slip;
		for (int i = 0; i < 9; i++) pulse(1'b1);
		chk("cells", 7, slip_cells);
		chk("source", 1, slip_source);
		past_target <= 1'b1;
		for (int i = 0; i < 600 && slip_cells !== 3'h0; i++) @(posedge clock);
		chk("cells", 0, slip_cells);
		past_target <= 1'b0;
		pulse(1'b0);
		chk("cells", 1, slip_cells);
		chk("source", 0, slip_source);
		put(3'h3, f3(1'b0, 1'b0, SCW_CLKDIV_RESYNC, 12'h005));
		put(3'h2, f2(1'b1, 1'b0, 10'd2));
		settle;
		chk("cells", 0, slip_cells);
		chk("assist", 0, slip_assist_enable);
		chk("cancel", 0, charge_cancel_en);
		chk("mode", SCW_CLKDIV_RESYNC, clkdiv_mode);
		repeat (600) @(posedge clock);
		chk("refgap", 2, ref_gap);
		chk("pfdgap", 5, pfd_gap);
	endtask
	task t_off;
		int n0;
		put(3'h3, f3(1'b0, 1'b0, SCW_CLKDIV_OFF, 12'h005));
		settle;
		chk("mode", SCW_CLKDIV_OFF, clkdiv_mode);
		n0 = tout_n;
		repeat (300) @(posedge clock);
		chk("timeouts", 0, tout_n - n0);
	endtask
	task tally_and_finish;
		if (n_fail == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		{wr, rd, slip_imminent, slip_dir_up, past_target} = 5'h00;
		addr = 3'h0;
		wdata = 32'h0;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		t_init;
		t_slip;
		t_off;
		tally_and_finish;
	end
	// watchdog well past the expected run length
	initial begin
		repeat (60000) @(posedge clock);
		n_fail++;
		tally_and_finish;
	end
endmodule

/* logic/scw_device.sv */
// scw_device: shifts in control words, decodes registers, slip sequencer
// assumes: link pins asynchronous to clock; synchronised here
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module scw_device (
	input wire logic clock,
	input wire logic rst_b,
	scw_if.device link,
	input wire logic ref_tick, // reference edge pulse, same clock
	input wire logic slip_imminent, // slip detector pulse
	input wire logic slip_dir_up, // tuning must rise
	input wire logic past_target, // oscillator passed target
	output logic charge_cancel_en,
	output logic slip_assist_enable,
	output scw_pkg::scw_clkdiv_e clkdiv_mode,
	output logic [11:0] clkdiv_value,
	output logic [1:0] lock_pin_mode,
	output logic [31:0] reserved_fixed_word,
	output logic [11:0] denominator_setting,
	output logic pfd_tick, // comparator clock enable
	output logic pfd_level, // 50% duty comparator clock
	output logic timeout_pulse, // divider timeout event
	output logic [2:0] slip_cells, // extra cells active
	output logic slip_source // 1 source, 0 sink
);
	import scw_pkg::*;
	// =========================================================
	// pin synchronisers: three stages, second and third agree
	logic [2:0] sclk_s, sdata_s, le_s;
	logic sclk_q, le_q; // filtered levels
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sclk_s <= 3'h0;
			sdata_s <= 3'h0;
			le_s <= 3'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], link.sclk};
			sdata_s <= {sdata_s[1:0], link.sdata};
			le_s <= {le_s[1:0], link.latch_en};
		end
	end
	// filtered level only moves when stages two and three agree
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sclk_q <= 1'b0;
			le_q <= 1'b0;
		end else begin
			if (sclk_s[1] == sclk_s[2]) sclk_q <= sclk_s[2];
			if (le_s[1] == le_s[2]) le_q <= le_s[2];
		end
	end
	wire sclk_rise = (sclk_s[1] == sclk_s[2]) && sclk_s[2] && !sclk_q;
	wire le_rise = (le_s[1] == le_s[2]) && le_s[2] && !le_q;
	// =========================================================
	// shift register, msb first
	logic [31:0] shift;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) shift <= 32'h0000_0000;
		else if (sclk_rise) shift <= {shift[30:0], sdata_s[2]};
	end
	// last bit and load strobe arrive together; fold that bit in first
	wire [31:0] word = sclk_rise ? {shift[30:0], sdata_s[2]} : shift;
	wire [2:0] sel = word[SEL_LSB +: SEL_W];
	// =========================================================
	// register bank loaded on latch enable
	logic [31:0] reg1, reg2;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reg1 <= 32'h0000_0000;
			reg2 <= 32'h0000_0000;
			charge_cancel_en <= 1'b0;
			slip_assist_enable <= 1'b0;
			clkdiv_mode <= SCW_CLKDIV_OFF;
			clkdiv_value <= 12'h000;
			lock_pin_mode <= 2'h0;
			reserved_fixed_word <= 32'h0000_0000;
		end else if (le_rise) begin
			case (sel)
				SEL_REG1: reg1 <= word;
				SEL_REG2: reg2 <= word;
				SEL_REG3: begin
					charge_cancel_en <= word[R3_CANCEL_BIT];
					slip_assist_enable <= word[R3_SLIP_BIT];
					clkdiv_mode <= scw_clkdiv_e'(word[R3_MODE_LSB +: 2]);
					clkdiv_value <= word[R3_DIV_LSB +: DIV_W];
				end
				SEL_REG4: reserved_fixed_word <= word;
				SEL_REG5: lock_pin_mode <= word[R5_LOCK_LSB +: 2];
				default: ;
			endcase
		end
	end
	// modulus over full 12-bit range
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) denominator_setting <= 12'h000;
		else denominator_setting <= reg1[R1_MOD_LSB +: DIV_W];
	end
	// =========================================================
	// comparator path: doubler, r counter, halving stage
	// fpfd = ref*(1+D)/(R*(1+T)); output freq follows
	// from the divider set (int+partial_step_count/mod) applied to pfd ticks
	wire dbl = reg2[R2_DBL_BIT];
	wire half = reg2[R2_HALF_BIT];
	wire [9:0] rdiv = reg2[R2_RCNT_LSB +: RCNT_W];
	logic ref_phase; // doubler: both edges counted
	logic [9:0] rcnt;
	logic r_out;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) ref_phase <= 1'b0;
		else if (ref_tick) ref_phase <= !ref_phase;
	end
	// without doubler only every second tick is active; doubler uses all
	wire ref_active = ref_tick && (dbl || ref_phase);
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rcnt <= 10'h000;
			r_out <= 1'b0;
		end else begin
			r_out <= 1'b0;
			if (ref_active) begin
				if (rcnt + 10'h001 >= rdiv || rdiv == 10'h000) begin
					rcnt <= 10'h000;
					r_out <= 1'b1;
				end else begin
					rcnt <= rcnt + 10'h001;
				end
			end
		end
	end
	// halving toggle flip-flop gives a 50% duty level
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pfd_level <= 1'b0;
			pfd_tick <= 1'b0;
		end else begin
			pfd_tick <= 1'b0;
			if (r_out) begin
				pfd_level <= !pfd_level;
				pfd_tick <= !half || pfd_level;
			end
		end
	end
	// =========================================================
	// clock divider timeout counter in pfd ticks
	logic [11:0] tcnt;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tcnt <= 12'h000;
			timeout_pulse <= 1'b0;
		end else begin
			timeout_pulse <= 1'b0;
			if (clkdiv_mode == SCW_CLKDIV_OFF || le_rise) begin
				tcnt <= 12'h000;
			end else if (pfd_tick) begin
				if (tcnt + 12'h001 >= clkdiv_value) begin
					tcnt <= 12'h000;
					timeout_pulse <= 1'b1;
				end else begin
					tcnt <= tcnt + 12'h001;
				end
			end
		end
	end
	// =========================================================
	// slip sequencer: climb on slips, fall after passing target
	typedef enum logic [2:0] {
		SCW_SLIP_IDLE = 3'b001,
		SCW_SLIP_CLIMB = 3'b010,
		SCW_SLIP_FALL = 3'b100
	} scw_slip_e;
	scw_slip_e slip_state;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			slip_state <= SCW_SLIP_IDLE;
			slip_cells <= 3'h0;
			slip_source <= 1'b0;
		end else if (!slip_assist_enable) begin
			slip_state <= SCW_SLIP_IDLE;
			slip_cells <= 3'h0;
		end else begin
			case (slip_state)
				SCW_SLIP_IDLE: begin
					if (slip_imminent) begin
						slip_cells <= 3'h1;
						slip_source <= slip_dir_up;
						slip_state <= SCW_SLIP_CLIMB;
					end
				end
				SCW_SLIP_CLIMB: begin
					if (past_target) begin
						slip_state <= SCW_SLIP_FALL;
					end else if (slip_imminent &&
						slip_cells != SLIP_MAX_CELLS) begin
						slip_cells <= slip_cells + 3'h1;
					end
				end
				SCW_SLIP_FALL: begin
					if (pfd_tick) begin
						slip_cells <= slip_cells - 3'h1;
						if (slip_cells == 3'h1) slip_state <= SCW_SLIP_IDLE;
					end
				end
				default: slip_state <= SCW_SLIP_IDLE;
			endcase
		end
	end
endmodule

/* logic/scw_host.sv */
// scw_host: writes control words over the three-wire link
// assumes: software drives a plain strobe port; device end on the link
`timescale 1ns/1ps
module scw_host (
	input wire logic clock,
	input wire logic rst_b,
	scw_if.host link,
	input wire logic [2:0] addr, // word index 0..5
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata
);
	import scw_pkg::*;
	// =========================================================
	// shadow words; index equals register select
	logic [31:0] shadow [0:5];
	logic [5:0] pending; // words waiting to send
	logic busy;
	logic [2:0] cur;
	logic [5:0] bitn;
	logic [3:0] div;
	logic phase; // 0 data setup, 1 clock high
	logic le_hold;
	logic init_done;
	logic init_go; // full set seen once, link open from then on
	// select highest pending index, so init goes 5 down to 0
	function automatic logic [2:0] pick(input logic [5:0] p);
		pick = 3'h0;
		for (int i = 0; i < 6; i++) if (p[i]) pick = 3'(i);
	endfunction
	// software writes store the word, forcing select bits, except index 4 stores R4_FIXED
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 6; i++) shadow[i] <= 32'h0000_0000;
		end else if (wr && addr <= 3'h5) begin
			if (addr == SEL_REG4) shadow[addr] <= R4_FIXED;
			else shadow[addr] <= {wdata[31:3], addr};
		end
	end
	// read data one cycle later; status at index 7
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) rdata <= 32'h0000_0000;
		else if (rd) begin
			if (addr <= 3'h5) rdata <= shadow[addr];
			else if (addr == 3'h7) rdata <= {24'h00_0000, init_done, busy, pending};
			else rdata <= 32'h0000_0000;
		end
	end
	// serial engine: one word per pending bit, msb first
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pending <= 6'h00;
			busy <= 1'b0;
			cur <= 3'h0;
			bitn <= 6'h00;
			div <= 4'h0;
			phase <= 1'b0;
			le_hold <= 1'b0;
			init_done <= 1'b0;
			init_go <= 1'b0;
			link.sclk <= 1'b0;
			link.sdata <= 1'b0;
			link.latch_en <= 1'b0;
		end else begin
			// hold words until all six are written once
			if (wr && addr <= 3'h5) pending[addr] <= 1'b1;
			if (!busy) begin
				link.latch_en <= 1'b0;
				// without this the burst stalls after its first word
				if (pending == 6'h3f) init_go <= 1'b1;
				if (pending != 6'h00 && (init_go || pending == 6'h3f)) begin
					cur <= pick(pending);
					busy <= 1'b1;
					bitn <= 6'h00;
					div <= 4'h0;
					phase <= 1'b0;
				end
			end else if (div != SCLK_HALF) begin
				div <= div + 4'h1;
			end else begin
				div <= 4'h0;
				if (le_hold) begin
					link.latch_en <= 1'b0;
					le_hold <= 1'b0;
					busy <= 1'b0;
					if (!(wr && addr == cur)) pending[cur] <= 1'b0;
					if (cur == 3'h0) init_done <= 1'b1;
				end else if (!phase) begin
					link.sdata <= shadow[cur][5'(BIT_LAST - bitn)];
					link.sclk <= 1'b0;
					phase <= 1'b1;
				end else begin
					link.sclk <= 1'b1;
					phase <= 1'b0;
					if (bitn == BIT_LAST) begin
						link.latch_en <= 1'b1;
						le_hold <= 1'b1;
					end
					bitn <= bitn + 6'h01;
				end
			end
		end
	end
endmodule

/* logic/scw_if.sv */
// scw_if: three-wire serial link between host and synthesizer
// assumes: one clock shared by both ends; testbench instantiates it
`timescale 1ns/1ps
interface scw_if;
	logic sclk; // serial clock, host driven
	logic sdata; // serial data, msb first
	logic latch_en; // rising edge loads shifted word
	modport host (output sclk, output sdata, output latch_en);
	modport device (input sclk, input sdata, input latch_en);
endinterface

/* logic/scw_pkg.sv */
// scw_pkg: shared constants and types for the synthesizer control-word path
// assumes: both ends compile this package first
package scw_pkg;
	// =========================================================
	// control word layout
	localparam int WORD_W = 32; // serial word width
	localparam int SEL_LSB = 0; // register select field low bit
	localparam int SEL_W = 3; // register select width
	localparam logic [2:0] SEL_REG0 = 3'h0;
	localparam logic [2:0] SEL_REG1 = 3'h1;
	localparam logic [2:0] SEL_REG2 = 3'h2;
	localparam logic [2:0] SEL_REG3 = 3'h3; // pattern 0,1,1
	localparam logic [2:0] SEL_REG4 = 3'h4; // pattern 1,0,0
	localparam logic [2:0] SEL_REG5 = 3'h5; // pattern 1,0,1
	// register 3 fields
	localparam int R3_CANCEL_BIT = 21;
	localparam int R3_SLIP_BIT = 18;
	localparam int R3_MODE_LSB = 15;
	localparam int R3_DIV_LSB = 3;
	localparam int DIV_W = 12;
	// register 4 fixed value: bit 23 set, plus select value 4 (bit 2) in the low bits
	localparam logic [31:0] R4_FIXED = 32'h0080_0004;
	// register 5 field
	localparam int R5_LOCK_LSB = 22;
	// register 1 / 2 fields used for frequency plan
	localparam int R1_MOD_LSB = 3;
	localparam int R2_RCNT_LSB = 14;
	localparam int R2_HALF_BIT = 24;
	localparam int R2_DBL_BIT = 25;
	localparam int RCNT_W = 10;
	// clock divider modes
	typedef enum logic [1:0] {
		SCW_CLKDIV_OFF = 2'b00,
		SCW_CLKDIV_FAST = 2'b01,
		SCW_CLKDIV_RESYNC = 2'b10,
		SCW_CLKDIV_RSVD = 2'b11
	} scw_clkdiv_e;
	// slip assist limits
	localparam logic [2:0] SLIP_MAX_CELLS = 3'h7;
	// serial timing: one serial clock per N system clocks
	localparam logic [3:0] SCLK_HALF = 4'h2;
	localparam logic [2:0] REG_LAST = 3'h5; // first register in init order
	localparam logic [5:0] BIT_LAST = 6'h1f;
endpackage
